// ### design/sdar_consts.vh
`ifndef SDAR_CONSTS_VH
`define SDAR_CONSTS_VH
// Register offsets on the special function register port
`define SDAR_OFS_DATA 8'hC2
`define SDAR_OFS_ADDR 8'hC3
// Reset values
`define SDAR_DATA_RST 8'h00
`define SDAR_ADDR_RST 8'h00
// Field positions
`define SDAR_GC_BIT 0
`define SDAR_EVENT_BIT 3
// General call address
`define SDAR_GC_ADDR 7'h00
// Default clock-high timeout in microseconds and system clock in MHz
`define SDAR_THIGH_US 50
`define SDAR_CLK_MHZ 125
`define SDAR_THIGH_CYC (`SDAR_THIGH_US * `SDAR_CLK_MHZ)
`endif

// ### design/sdar_fifo.v
`timescale 1ns/1ps
`default_nettype none
module sdar_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire sys_clk,
    input wire reset,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    // Depth and last index as sized constants, so no bit-select of an untyped parameter is needed
    localparam [AW:0] DEPTH_W = DEPTH;
    localparam [AW:0] LAST_W = DEPTH - 1;
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    // Full and empty come straight from the occupancy count
    assign in_ready = (cnt_q != DEPTH_W);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers wrap at the depth, which need not be a power of two
    always @(posedge sys_clk) begin
        if (reset) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= ({1'b0, wr_q} == LAST_W) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= ({1'b0, rd_q} == LAST_W) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### design/sdar_top.v
// What this block does
// - No shift starts while the serial event flag is set; software writes to the data register still land.
// - Bytes go onto the bus most significant bit first.
// - First received bit ends up in bit 7 of the data register.
// - Bus level is shifted in while shifting out; register keeps bus byte.
// - Lost arbitration turns master transmitter into slave receiver, data kept.
// - Own address register holds the 7-bit slave address in bits 7 to 1.
// - Address bit 0 set enables recognition of general call address zero.
// - Own address register is ignored while operating as bus master.
// - Both registers are read/write and reset to zero.
// - Clock-high timeout reported only while free-timeout enable is set.
`timescale 1ns/1ps
`default_nettype none
`include "sdar_consts.vh"
module sdar_top #(
    parameter THIGH_CYC = `SDAR_THIGH_CYC,
    parameter FIFO_DEPTH = 8
) (
    input wire sys_clk,
    input wire reset,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    input wire [7:0] serial_control_reg,
    input wire master_mode,
    input wire free_timeout_enable,
    input wire tx_start,
    input wire rx_start,
    input wire addr_phase,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    output reg byte_done,
    output reg arb_lost,
    output reg addr_match,
    output reg gc_match,
    output reg timeout,
    output reg [7:0] rx_byte,
    output reg rx_valid,
    input wire rx_ready
);
    localparam ST_IDLE = 2'd0;
    localparam ST_SHIFT = 2'd1;
    localparam ST_DONE = 2'd2;

    reg [7:0] serial_data_byte_q;
    reg [7:0] own_slave_address_q;
    reg [1:0] state_q;
    reg [3:0] bit_cnt_q;
    reg tx_mode_q;
    reg scl_s1_q, scl_s2_q, scl_s3_q;
    reg sda_s1_q, sda_s2_q;
    reg [31:0] high_cnt_q;
    wire scl_rise;
    wire scl_fall;
    wire serial_event;
    wire [6:0] slave_address_bits;
    wire general_call_enable;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg fifo_push_q;
    reg [7:0] fifo_wdata_q;

    assign serial_event = serial_control_reg[`SDAR_EVENT_BIT];
    assign slave_address_bits = own_slave_address_q[7:1];
    assign general_call_enable = own_slave_address_q[`SDAR_GC_BIT];

    // Pin synchronisers; the third stage is only for edge finding
    always @(posedge sys_clk) begin
        if (reset) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
        end
    end
    assign scl_rise = scl_s2_q && !scl_s3_q;
    assign scl_fall = !scl_s2_q && scl_s3_q;

    // Shift engine and register writes; data register writes lose to a running shift, address register writes always land
    always @(posedge sys_clk) begin
        if (reset) begin
            serial_data_byte_q <= `SDAR_DATA_RST;
            own_slave_address_q <= `SDAR_ADDR_RST;
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'd0;
            tx_mode_q <= 1'b0;
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
            byte_done <= 1'b0;
            arb_lost <= 1'b0;
            addr_match <= 1'b0;
            gc_match <= 1'b0;
            fifo_push_q <= 1'b0;
            fifo_wdata_q <= 8'h00;
        end else begin
            byte_done <= 1'b0;
            arb_lost <= 1'b0;
            fifo_push_q <= 1'b0;
            if (sfr_wr && sfr_addr == `SDAR_OFS_ADDR) begin
                own_slave_address_q <= sfr_wdata;
            end
            case (state_q)
                ST_IDLE: begin
                    // no shifting while event flag set
                    if (sfr_wr && sfr_addr == `SDAR_OFS_DATA) begin
                        serial_data_byte_q <= sfr_wdata;
                    end else if (!serial_event && (tx_start || rx_start)) begin
                        state_q <= ST_SHIFT;
                        bit_cnt_q <= 4'd0;
                        tx_mode_q <= tx_start;
                        addr_match <= 1'b0;
                        gc_match <= 1'b0;
                        sda_out <= tx_start ? serial_data_byte_q[7] : 1'b1;
                        sda_oe <= tx_start && !serial_data_byte_q[7];
                    end
                end
                ST_SHIFT: begin
                    if (scl_rise) begin
                        // sample into LSB, first bit reaches bit 7
                        serial_data_byte_q <= {serial_data_byte_q[6:0], sda_s2_q};
                        bit_cnt_q <= bit_cnt_q + 4'd1;
                        // lost arbitration, keep shifting as receiver
                        if (tx_mode_q && sda_out && !sda_s2_q) begin
                            tx_mode_q <= 1'b0;
                            arb_lost <= 1'b1;
                            sda_oe <= 1'b0;
                            sda_out <= 1'b1;
                        end
                    end else if (scl_fall && bit_cnt_q != 4'd0) begin
                        if (bit_cnt_q == 4'd8) begin
                            state_q <= ST_DONE;
                            sda_oe <= 1'b0;
                            sda_out <= 1'b1;
                        end else if (tx_mode_q) begin
                            sda_out <= serial_data_byte_q[7];
                            sda_oe <= !serial_data_byte_q[7];
                        end
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                    byte_done <= 1'b1;
                    fifo_push_q <= fifo_in_ready;
                    fifo_wdata_q <= serial_data_byte_q;
                    // compare 7 address bits, slave only
                    if (addr_phase && !master_mode) begin
                        addr_match <= (serial_data_byte_q[7:1] == slave_address_bits);
                        gc_match <= general_call_enable && (serial_data_byte_q[7:1] == `SDAR_GC_ADDR);
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // clock-high timer, gated by free-timeout enable
    always @(posedge sys_clk) begin
        if (reset) begin
            high_cnt_q <= 32'd0;
            timeout <= 1'b0;
        end else if (!free_timeout_enable || !scl_s2_q) begin
            high_cnt_q <= 32'd0;
            timeout <= 1'b0;
        end else if (high_cnt_q >= THIGH_CYC) begin
            timeout <= 1'b1;
        end else begin
            high_cnt_q <= high_cnt_q + 32'd1;
        end
    end

    // Register read port, unmapped offsets read zero
    always @(posedge sys_clk) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd && sfr_addr == `SDAR_OFS_DATA) begin
            sfr_rdata <= serial_data_byte_q;
        end else if (sfr_rd && sfr_addr == `SDAR_OFS_ADDR) begin
            sfr_rdata <= own_slave_address_q;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    // Received bytes stream through the FIFO; a full FIFO drops the copy only
    sdar_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(fifo_push_q),
        .in_ready(fifo_in_ready),
        .in_data(fifo_wdata_q),
        .out_valid(fifo_out_valid),
        .out_ready(rx_ready && (!rx_valid || rx_ready)),
        .out_data(fifo_out_data)
    );

    // Output stage register so the stream port comes from flip-flops
    always @(posedge sys_clk) begin
        if (reset) begin
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_valid <= fifo_out_valid && rx_ready;
            rx_byte <= fifo_out_data;
        end
    end
endmodule
`default_nettype wire

// ### sim/sdar_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sdar_peer (
    output logic scl,
    output logic sda
);
    // SCL rests low between bytes so no edge is seen outside a frame
    initial begin
        scl = 1'b0;
        sda = 1'b1;
    end
    // One byte, first bit first, on a 64 ns link clock; a 1 is the released line
    task automatic run(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda = b[i];
            #16 scl = 1'b1;
            #32 scl = 1'b0;
            #16;
        end
        sda = 1'b1;
    endtask
    // Park the clock line, used to stretch a high period
    task automatic park(input logic v);
        scl = v;
    endtask
endmodule
`default_nettype wire

// ### sim/sdar_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdar_consts.vh"
module sdar_sva #(
    parameter int THIGH_CYC = 20
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] serial_control_reg,
    input wire logic master_mode,
    input wire logic free_timeout_enable,
    input wire logic tx_start,
    input wire logic rx_start,
    input wire logic scl_in,
    input wire logic sda_oe,
    input wire logic byte_done,
    input wire logic arb_lost,
    input wire logic addr_match,
    input wire logic gc_match,
    input wire logic timeout
);
    logic [7:0] adr_q;
    logic [15:0] hi_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Shadow of the address register; only software ever writes it, so the copy is exact
    always @(posedge sys_clk) begin
        if (reset) begin
            adr_q <= 8'h00;
            hi_q <= 16'h0000;
        end else begin
            if (sfr_wr && sfr_addr == `SDAR_OFS_ADDR) adr_q <= sfr_wdata;
            hi_q <= (scl_in && free_timeout_enable) ? hi_q + 16'h0001 : 16'h0000;
        end
    end
    property p_unmapped; sfr_rd && sfr_addr != `SDAR_OFS_DATA && sfr_addr != `SDAR_OFS_ADDR |=> sfr_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_adr_read; sfr_rd && !sfr_wr && sfr_addr == `SDAR_OFS_ADDR |=> sfr_rdata == adr_q; endproperty
    a_adr_read: assert property (p_adr_read) else $error("address register readback wrong");
    property p_master; $rose(addr_match) || $rose(gc_match) |-> !master_mode; endproperty
    a_master: assert property (p_master) else $error("match raised in master mode");
    property p_done; byte_done |=> !byte_done; endproperty
    a_done: assert property (p_done) else $error("byte done longer than one cycle");
    property p_arb; arb_lost |-> !sda_oe ##1 !sda_oe [*8]; endproperty
    a_arb: assert property (p_arb) else $error("still driving after arbitration loss");
    property p_tmo_en; $rose(timeout) |-> free_timeout_enable; endproperty
    a_tmo_en: assert property (p_tmo_en) else $error("timeout without enable");
    property p_tmo; hi_q >= THIGH_CYC + 8 |-> timeout; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout missing");
    property p_clr; (tx_start || rx_start) && !serial_control_reg[3] |=> !addr_match && !gc_match; endproperty
    a_clr: assert property (p_clr) else $error("match not cleared at start");
    c_match: cover property (byte_done ##1 addr_match);
    c_gc: cover property (gc_match);
    c_arb: cover property (arb_lost);
    c_tmo: cover property ($rose(timeout));
endmodule
`default_nettype wire

// ### sim/smbus_data_and_address_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdar_consts.vh"
bind sdar_top sdar_sva #(.THIGH_CYC(THIGH_CYC)) i_sdar_sva (.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .serial_control_reg(serial_control_reg), .master_mode(master_mode), .free_timeout_enable(free_timeout_enable),
    .tx_start(tx_start), .rx_start(rx_start), .scl_in(scl_in), .sda_oe(sda_oe), .byte_done(byte_done),
    .arb_lost(arb_lost), .addr_match(addr_match), .gc_match(gc_match), .timeout(timeout));
module smbus_data_and_address_regs_bench;
    logic sys_clk, reset, sfr_wr, sfr_rd, master_mode, free_timeout_enable, tx_start, rx_start, addr_phase, rx_ready;
    logic [7:0] sfr_addr, sfr_wdata, serial_control_reg, v, mon;
    logic arb_seen;
    wire [7:0] sfr_rdata, rx_byte;
    wire sda_out, sda_oe, byte_done, arb_lost, addr_match, gc_match, timeout, rx_valid, scl_w, sda_w, sda_in;
    int n_mismatch, cmp_count;
    // Open-drain wire: the peer's level unless the block pulls low
    assign sda_in = sda_w & ~sda_oe;
    sdar_peer i_sdar_peer (.scl(scl_w), .sda(sda_w));
    sdar_top #(.THIGH_CYC(20), .FIFO_DEPTH(8)) i_sdar_top (.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .serial_control_reg(serial_control_reg), .master_mode(master_mode), .free_timeout_enable(free_timeout_enable),
        .tx_start(tx_start), .rx_start(rx_start), .addr_phase(addr_phase), .scl_in(scl_w), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .byte_done(byte_done), .arb_lost(arb_lost), .addr_match(addr_match),
        .gc_match(gc_match), .timeout(timeout), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready));
    // Wire monitor: bits as seen on each clock rise
    always @(posedge scl_w) mon <= {mon[6:0], sda_in};
    always @(posedge sys_clk) if (arb_lost === 1'b1) arb_seen <= 1'b1;
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task tick; @(posedge sys_clk); #1; endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        tick; sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
        tick; sfr_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a);
        tick; sfr_addr = a; sfr_rd = 1'b1;
        tick; sfr_rd = 1'b0; v = sfr_rdata;
    endtask
    // One byte on the link; software keeps off the data register until the byte is done
    task xb(input logic tx, input logic [7:0] pb);
        int k;
        tick; tx_start = tx; rx_start = ~tx;
        tick; tx_start = 1'b0; rx_start = 1'b0;
        fork i_sdar_peer.run(pb); join_none
        for (k = 0; k < 200 && byte_done !== 1'b1; k++) tick;
        if (k == 200) begin n_mismatch++; $display("CHECK FAILED byte_done expected 1 seen timeout"); results; end
    endtask
    task t_regs;
        rd(`SDAR_OFS_DATA); chk("data reset", `SDAR_DATA_RST, v);
        rd(`SDAR_OFS_ADDR); chk("addr reset", `SDAR_ADDR_RST, v);
        rd(8'hC4); chk("unmapped", 8'h00, v);
        wr(`SDAR_OFS_DATA, 8'hA6); wr(`SDAR_OFS_ADDR, 8'h5B);
        rd(`SDAR_OFS_DATA); chk("data rw", 8'hA6, v);
        rd(`SDAR_OFS_ADDR); chk("addr rw", 8'h5B, v);
    endtask
    // Nine bytes into an eight-word buffer with the reader stalled, then drain
    task t_stream;
        int n;
        logic [7:0] first;
        n = 0;
        for (int i = 0; i < 9; i++) xb(1'b0, 8'h10 + i[7:0]);
        rd(`SDAR_OFS_DATA); chk("rx data", 8'h18, v);
        rx_ready = 1'b1;
        repeat (24) begin tick; if (rx_valid === 1'b1) begin if (n == 0) first = rx_byte; n++; end end
        chk("fifo count", 8'h08, n[7:0]);
        chk("fifo first", 8'h10, first);
    endtask
    task t_tx;
        wr(`SDAR_OFS_DATA, 8'h3C); xb(1'b1, 8'hFF);
        chk("wire order", 8'h3C, mon);
        rd(`SDAR_OFS_DATA); chk("tx data", 8'h3C, v);
        arb_seen = 1'b0; wr(`SDAR_OFS_DATA, 8'hFF); xb(1'b1, 8'hBF);
        chk("arb lost", 8'h01, {7'h00, arb_seen});
        rd(`SDAR_OFS_DATA); chk("arb data", 8'hBF, v);
    endtask
    task t_addr;
        logic [7:0] own [5];
        logic [7:0] byt [5];
        logic [2:0] fl [5];
        own = '{8'h54, 8'h54, 8'h54, 8'h55, 8'h54};
        byt = '{8'h55, 8'hD5, 8'h55, 8'h00, 8'h00};
        fl = '{3'h2, 3'h0, 3'h4, 3'h1, 3'h0};
        addr_phase = 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(`SDAR_OFS_ADDR, own[i]); master_mode = fl[i][2]; xb(1'b0, byt[i]); tick;
            chk("match", {6'h00, fl[i][1:0]}, {6'h00, addr_match, gc_match});
        end
        addr_phase = 1'b0; master_mode = 1'b0;
    endtask
    task t_event;
        int n;
        n = 0;
        serial_control_reg = 8'h08; wr(`SDAR_OFS_DATA, 8'h77);
        tick; rx_start = 1'b1; tick; rx_start = 1'b0;
        fork i_sdar_peer.run(8'h00); join_none
        repeat (80) begin tick; if (byte_done !== 1'b0) n++; end
        chk("held done", 8'h00, n[7:0]);
        rd(`SDAR_OFS_DATA); chk("held data", 8'h77, v);
        serial_control_reg = 8'h00;
    endtask
    task t_tmo;
        i_sdar_peer.park(1'b1); repeat (40) tick;
        chk("timeout off", 8'h00, {7'h00, timeout});
        free_timeout_enable = 1'b1; repeat (40) tick;
        chk("timeout on", 8'h01, {7'h00, timeout});
        i_sdar_peer.park(1'b0); free_timeout_enable = 1'b0; tick;
    endtask
    initial begin
        {sfr_wr, sfr_rd, master_mode, free_timeout_enable, tx_start, rx_start, addr_phase, rx_ready} = 8'h00;
        {sfr_addr, sfr_wdata, serial_control_reg, mon} = 32'h0000_0000;
        arb_seen = 1'b0; n_mismatch = 0; cmp_count = 0; reset = 1'b1;
        repeat (12) @(posedge sys_clk);
        #1 reset = 1'b0;
        t_regs; t_stream; t_tx; t_addr; t_event; t_tmo;
        results;
    end
endmodule
`default_nettype wire
